// ### rtl/gpio_share_port.sv
// shared gpio port with pin mux, open drain, analog cfg and peripheral disable registers
`timescale 1ns/10ps
module gpio_share_port #(
  parameter int unsigned WIDTH = 16,
  parameter logic [15:0] PIN_VALID = 16'hffff,
  parameter logic [15:0] ANALOG_PINS = 16'h00ff,
  parameter logic [15:0] OUT_CAPABLE = 16'hffff,
  parameter int unsigned UNITS = 32
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [5:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [5:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_out,
  output logic [WIDTH-1:0] pin_oe,
  input wire logic [WIDTH-1:0] periph_out,
  input wire logic [WIDTH-1:0] periph_drive,
  input wire logic [WIDTH-1:0] periph_pin_owner_any,
  output logic [WIDTH-1:0] periph_in,
  output logic [WIDTH-1:0] analog_sel,
  output logic [UNITS-1:0] unit_enable
);
  // periph_pin_owner_any: per pin, the sharing peripheral is enabled by its own unit gating
  typedef struct packed {
    logic [WIDTH-1:0] dir;
    logic [WIDTH-1:0] lat;
    logic [WIDTH-1:0] odc;
    logic [WIDTH-1:0] acfg;
    logic [15:0] pma;
    logic [15:0] pmb;
    logic [15:0] pmc;
    logic aw_got;
    logic w_got;
    logic [5:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [WIDTH-1:0] pout;
    logic [WIDTH-1:0] poe;
    logic [WIDTH-1:0] pin_s;
    logic [WIDTH-1:0] pins;
    logic [WIDTH-1:0] asel;
    logic [UNITS-1:0] uen;
  } state_t;

  state_t state_reg;
  state_t state_next;
  logic [WIDTH-1:0] own;
  logic [WIDTH-1:0] adig;
  logic [15:0] wval;
  logic [15:0] rv;
  logic [WIDTH-1:0] pinread;
  logic adc_off;
  // reset pattern cut to the port width, declared before the checks that read it
  localparam logic [WIDTH-1:0] RST_DIR_W = gpio_share_pkg::RST_DIR[WIDTH-1:0];

  always_comb begin
    state_next = state_reg;
    wval = '0;
    rv = '0;
    // either adc disabled
    // one shared cfg register, so a single disabled converter frees every analog pin
    adc_off = state_reg.pma[gpio_share_pkg::PMA_ADC1] | state_reg.pmc[gpio_share_pkg::PMC_ADC2];
    adig = adc_off ? ANALOG_PINS : (state_reg.acfg & ANALOG_PINS);
    // peripheral drives only while enabled and active; input only pins never claim
    // output capable mask keeps input only sharers off the mux
    own = periph_drive & periph_pin_owner_any & OUT_CAPABLE & PIN_VALID;
    pinread = state_reg.pins & PIN_VALID & ~(ANALOG_PINS & ~adig);

    // axi write path, address and data in either order
    if (s_axi_awvalid && !state_reg.aw_got) begin
      state_next.aw_got = 1'b1;
      state_next.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !state_reg.w_got) begin
      state_next.w_got = 1'b1;
      state_next.wdata = s_axi_wdata;
      state_next.wstrb = s_axi_wstrb;
    end
    if (state_reg.aw_got && state_reg.w_got && !state_reg.bvalid) begin
      wval[7:0] = state_reg.wstrb[0] ? state_reg.wdata[7:0] : 8'h00;
      wval[15:8] = state_reg.wstrb[1] ? state_reg.wdata[15:8] : 8'h00;
      state_next.aw_got = 1'b0;
      state_next.w_got = 1'b0;
      state_next.bvalid = 1'b1;
      state_next.bresp = gpio_share_pkg::RESP_OKAY;
      case (state_reg.awaddr)
        gpio_share_pkg::OFF_DIR: state_next.dir = merge(state_reg.dir, wval, state_reg.wstrb) & PIN_VALID;
        gpio_share_pkg::OFF_LAT: state_next.lat = merge(state_reg.lat, wval, state_reg.wstrb) & PIN_VALID;
        // pin write goes to the latch
        gpio_share_pkg::OFF_PIN: state_next.lat = merge(state_reg.lat, wval, state_reg.wstrb) & PIN_VALID;
        gpio_share_pkg::OFF_ODC: state_next.odc = merge(state_reg.odc, wval, state_reg.wstrb) & PIN_VALID;
        gpio_share_pkg::OFF_ACFG: state_next.acfg = merge(state_reg.acfg, wval, state_reg.wstrb) & ANALOG_PINS;
        gpio_share_pkg::OFF_PMA: state_next.pma = merge(state_reg.pma, wval, state_reg.wstrb) & gpio_share_pkg::PMA_MASK;
        gpio_share_pkg::OFF_PMB: state_next.pmb = merge(state_reg.pmb, wval, state_reg.wstrb) & gpio_share_pkg::PMB_MASK;
        gpio_share_pkg::OFF_PMC: state_next.pmc = merge(state_reg.pmc, wval, state_reg.wstrb) & gpio_share_pkg::PMC_MASK;
        default: state_next.bresp = gpio_share_pkg::RESP_SLVERR;
      endcase
    end
    if (state_reg.bvalid && s_axi_bready) begin
      state_next.bvalid = 1'b0;
    end

    // axi read path
    if (s_axi_arvalid && !state_reg.rvalid) begin
      state_next.rvalid = 1'b1;
      state_next.rresp = gpio_share_pkg::RESP_OKAY;
      case (s_axi_araddr)
        gpio_share_pkg::OFF_DIR: rv = state_reg.dir;
        gpio_share_pkg::OFF_LAT: rv = state_reg.lat;
        gpio_share_pkg::OFF_PIN: rv = pinread;
        gpio_share_pkg::OFF_ODC: rv = state_reg.odc;
        gpio_share_pkg::OFF_ACFG: rv = state_reg.acfg;
        gpio_share_pkg::OFF_PMA: rv = state_reg.pma;
        gpio_share_pkg::OFF_PMB: rv = state_reg.pmb;
        gpio_share_pkg::OFF_PMC: rv = state_reg.pmc;
        default: state_next.rresp = gpio_share_pkg::RESP_SLVERR;
      endcase
      state_next.rdata = {16'h0000, rv};
    end else if (state_reg.rvalid && s_axi_rready) begin
      state_next.rvalid = 1'b0;
    end

    // pin registered two cycles so a read right after a write may see old level
    state_next.pin_s = pin_in;
    state_next.pins = state_reg.pin_s;
    // open drain drives only a low
    // idle peripheral leaves port in charge
    for (int i = 0; i < WIDTH; i++) begin
      if (own[i]) begin
        state_next.pout[i] = periph_out[i];
        state_next.poe[i] = 1'b1;
      end else if (!state_reg.dir[i] && PIN_VALID[i]) begin
        state_next.pout[i] = state_reg.odc[i] ? 1'b0 : state_reg.lat[i];
        state_next.poe[i] = state_reg.odc[i] ? ~state_reg.lat[i] : 1'b1;
      end else begin
        state_next.pout[i] = 1'b0;
        state_next.poe[i] = 1'b0;
      end
    end
    state_next.asel = ANALOG_PINS & ~adig;
    state_next.uen = '0;
    state_next.uen[1:0] = ~state_reg.pma[1:0];
    state_next.uen[17:2] = ~state_reg.pmb;
    state_next.uen[19:18] = ~state_reg.pmc[1:0];
    state_next.uen[23:20] = ~state_reg.pmc[15:12];
    if (srst) begin
      state_next = '0;
      state_next.dir = gpio_share_pkg::RST_DIR[WIDTH-1:0] & PIN_VALID;
      state_next.lat = gpio_share_pkg::RST_LAT[WIDTH-1:0];
      state_next.odc = gpio_share_pkg::RST_ODC[WIDTH-1:0];
      state_next.acfg = gpio_share_pkg::RST_ACFG[WIDTH-1:0];
      state_next.pma = gpio_share_pkg::RST_PM;
      state_next.pmb = gpio_share_pkg::RST_PM;
      state_next.pmc = gpio_share_pkg::RST_PM;
    end
  end

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nv, input logic [3:0] st);
    merge = old;
    if (st[0]) merge[7:0] = nv[7:0];
    if (st[1]) merge[15:8] = nv[15:8];
  endfunction

  always_ff @(posedge sys_clk) begin
    state_reg <= state_next;
  end

  assign s_axi_awready = ~state_reg.aw_got;
  assign s_axi_wready = ~state_reg.w_got;
  assign s_axi_bvalid = state_reg.bvalid;
  assign s_axi_bresp = state_reg.bresp;
  assign s_axi_arready = ~state_reg.rvalid;
  assign s_axi_rvalid = state_reg.rvalid;
  assign s_axi_rdata = state_reg.rdata;
  assign s_axi_rresp = state_reg.rresp;
  assign pin_out = state_reg.pout;
  assign pin_oe = state_reg.poe;
  // peripheral sees only the outside pin level, never the port latch
  assign periph_in = state_reg.pins;
  assign analog_sel = state_reg.asel;
  assign unit_enable = state_reg.uen;

  chk_pmc_unimpl: assert property (
    @(posedge sys_clk) disable iff (srst) state_reg.pmc[11:2] == 10'h000)
    else $error("third disable register unimplemented bits set");
  chk_reset_dir: assert property (
    @(posedge sys_clk) srst |=> state_reg.dir == (RST_DIR_W & PIN_VALID))
    else $error("direction not input after reset");
  chk_reset_pm: assert property (
    @(posedge sys_clk) srst |=> (state_reg.pma | state_reg.pmb | state_reg.pmc) == 16'h0000)
    else $error("disable bits not cleared by reset");
  chk_analog_reset: assert property (
    @(posedge sys_clk) srst |=> state_reg.acfg == '0)
    else $error("analog cfg not cleared by reset");
  chk_periph_own: assert property (
    @(posedge sys_clk) disable iff (srst) own[0] |=> pin_oe[0] && pin_out[0] == $past(periph_out[0]))
    else $error("peripheral not given the pin");
  chk_idle_port: assert property (
    @(posedge sys_clk) disable iff (srst)
    (!own[0] && !state_reg.dir[0] && !state_reg.odc[0] && PIN_VALID[0]) |=> pin_oe[0] && pin_out[0] == $past(state_reg.lat[0]))
    else $error("port latch not on idle pin");
  chk_dir_input: assert property (
    @(posedge sys_clk) disable iff (srst) (state_reg.dir[0] && !own[0]) |=> !pin_oe[0])
    else $error("input pin driven");
  chk_od_low: assert property (
    @(posedge sys_clk) disable iff (srst) (state_reg.odc[0] && !own[0]) |=> !(pin_oe[0] && pin_out[0]))
    else $error("open drain pin driven high");
  chk_od_release: assert property (
    @(posedge sys_clk) disable iff (srst)
    (state_reg.odc[0] && !own[0] && !state_reg.dir[0] && state_reg.lat[0]) |=> !pin_oe[0])
    else $error("open drain pin not released for high");
  chk_adc_digital: assert property (
    @(posedge sys_clk) disable iff (srst) adc_off |=> analog_sel == '0)
    else $error("analog selected while adc disabled");
  // peripheral sees outside level
  // two stage sample, so only look once both stages hold post-reset data
  chk_loop_block: assert property (
    @(posedge sys_clk) disable iff (srst) (!$past(srst) && !$past(srst, 2)) |-> periph_in == $past(pin_in, 2))
    else $error("peripheral input not taken from the pin");
  chk_unit_off: assert property (
    @(posedge sys_clk) disable iff (srst) state_reg.pmb[8] |=> !unit_enable[10])
    else $error("capture1 enabled while disabled");
  chk_capture8_off: assert property (
    @(posedge sys_clk) disable iff (srst) state_reg.pmb[15] |=> !unit_enable[17])
    else $error("capture8 enabled while disabled");
  chk_compare1_off: assert property (
    @(posedge sys_clk) disable iff (srst) state_reg.pmb[0] |=> !unit_enable[2])
    else $error("compare1 enabled while disabled");
  chk_timer9_off: assert property (
    @(posedge sys_clk) disable iff (srst) state_reg.pmc[15] |=> !unit_enable[23])
    else $error("timer9 enabled while disabled");
  chk_adc2_off: assert property (
    @(posedge sys_clk) disable iff (srst) state_reg.pmc[0] |=> !unit_enable[18] && analog_sel == '0)
    else $error("adc2 enabled while disabled");
  chk_can_off: assert property (
    @(posedge sys_clk) disable iff (srst) state_reg.pma[1] |=> !unit_enable[1])
    else $error("can1 enabled while disabled");
  chk_invalid_zero: assert property (
    @(posedge sys_clk) disable iff (srst) ((state_reg.dir | state_reg.lat) & ~PIN_VALID) == '0)
    else $error("nonexistent pin bits set");
  chk_absent_drive: assert property (
    @(posedge sys_clk) disable iff (srst) (pin_oe & ~PIN_VALID) == '0)
    else $error("nonexistent pin driven");
endmodule

// ### inc/gpio_share_pkg.sv
// constants for the shared gpio port with peripheral disable controls
package gpio_share_pkg;
  localparam int unsigned ADDR_W = 6;
  localparam logic [5:0] OFF_DIR = 6'h00;
  localparam logic [5:0] OFF_LAT = 6'h04;
  localparam logic [5:0] OFF_PIN = 6'h08;
  localparam logic [5:0] OFF_ODC = 6'h0c;
  localparam logic [5:0] OFF_ACFG = 6'h10;
  localparam logic [5:0] OFF_PMA = 6'h14;
  localparam logic [5:0] OFF_PMB = 6'h18;
  localparam logic [5:0] OFF_PMC = 6'h1c;
  localparam logic [15:0] RST_DIR = 16'hffff;
  localparam logic [15:0] RST_LAT = 16'h0000;
  localparam logic [15:0] RST_ODC = 16'h0000;
  localparam logic [15:0] RST_ACFG = 16'h0000;
  localparam logic [15:0] RST_PM = 16'h0000;
  localparam logic [15:0] PMA_MASK = 16'h0003;
  localparam logic [15:0] PMB_MASK = 16'hffff;
  localparam logic [15:0] PMC_MASK = 16'hf003;
  localparam int unsigned PMA_CAN1 = 1;
  localparam int unsigned PMA_ADC1 = 0;
  localparam int unsigned PMB_CAP_LO = 8;
  localparam int unsigned PMB_CMP_LO = 0;
  localparam int unsigned PMC_TMR_LO = 12;
  localparam int unsigned PMC_TWI2 = 1;
  localparam int unsigned PMC_ADC2 = 0;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// ### verification/gpio_share_peer.sv
// pin and peripheral model facing the shared port
`timescale 1ns/10ps
module gpio_share_peer (
  input wire logic [15:0] pin_out,
  input wire logic [15:0] pin_oe,
  input wire logic [15:0] ext_en,
  input wire logic [15:0] ext_val,
  input wire logic [31:0] unit_enable,
  input wire logic [15:0] drive_req,
  input wire logic [15:0] drive_val,
  output logic [15:0] pin_in,
  output logic [15:0] periph_out,
  output logic [15:0] periph_drive,
  output logic [15:0] periph_pin_owner_any
);
  // pull-up on every pin, so a released open drain line reads high
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ((ext_en & ext_val) | ~ext_en));
  // idle peripheral data is the pin inverted, so a wrong mux choice shows
  assign periph_out = (drive_req & drive_val) | (~drive_req & ~pin_out);
  assign periph_drive = drive_req;
  // compare units own pins 0..7, capture units pins 8..15
  assign periph_pin_owner_any = unit_enable[17:2];
endmodule

// ### verification/gpio_share_port_tb_top.sv
// self-checking bench for the shared gpio port
`timescale 1ns/10ps
module gpio_share_port_tb_top;
  logic sys_clk = 0;
  logic srst = 1;
  logic [5:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, unit_enable, rd;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [15:0] pin_in, pin_out, pin_oe, periph_out, periph_drive, periph_pin_owner_any, periph_in, analog_sel;
  logic [15:0] ext_en = '0, ext_val = '0, drive_req = '0, drive_val = '0;
  int err_total = 0, checked = 0;
  // bit 15 absent, pin 1 shared with an input-only unit
  gpio_share_port #(.PIN_VALID(16'h7fff), .OUT_CAPABLE(16'hfffd)) gpio_share_port_inst (.sys_clk, .srst,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pin_in, .pin_out, .pin_oe, .periph_out, .periph_drive,
    .periph_pin_owner_any, .periph_in, .analog_sel, .unit_enable);
  gpio_share_peer gpio_share_peer_inst (.pin_out, .pin_oe, .ext_en, .ext_val, .unit_enable, .drive_req,
    .drive_val, .pin_in, .periph_out, .periph_drive, .periph_pin_owner_any);
  initial forever #4 sys_clk = ~sys_clk;
  task close_out;
    if (err_total == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e, input string m);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("BAD %0t %s got %h", $time, m, g);
    end
  endtask
  task idle(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // handshakes sampled on the falling edge, half a cycle before the rising edge, so no race with the slave flops
  task wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er = gpio_share_pkg::RESP_OKAY);
    bit ta, tw, done;
    done = 0;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    for (int n = 0; n < 40 && !done; n++) begin
      @(negedge sys_clk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      done = s_axi_bvalid;
      rsp = s_axi_bresp;
      @(posedge sys_clk);
      if (ta) s_axi_awvalid <= 0;
      if (tw) s_axi_wvalid <= 0;
      if (done) s_axi_bready <= 0;
    end
    if (!done) begin
      err_total++;
      $display("BAD %0t write hang", $time);
      close_out;
    end
    chk(rsp, er, "write resp");
  endtask
  task rdr(input logic [5:0] a, input logic [31:0] e, input logic [1:0] er = gpio_share_pkg::RESP_OKAY);
    bit ta, done;
    done = 0;
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    for (int n = 0; n < 40 && !done; n++) begin
      @(negedge sys_clk);
      ta = s_axi_arvalid && s_axi_arready;
      done = s_axi_rvalid;
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge sys_clk);
      if (ta) s_axi_arvalid <= 0;
      if (done) s_axi_rready <= 0;
    end
    if (!done) begin
      err_total++;
      $display("BAD %0t read hang", $time);
      close_out;
    end
    chk(rd, e, "read data");
    chk(rsp, er, "read resp");
  endtask
  task t_reset;
    rdr(gpio_share_pkg::OFF_DIR, 32'h7fff);
    rdr(gpio_share_pkg::OFF_LAT, 32'h0);
    rdr(gpio_share_pkg::OFF_PMA, 32'h0);
    rdr(gpio_share_pkg::OFF_PMB, 32'h0);
    rdr(gpio_share_pkg::OFF_PMC, 32'h0);
    chk(pin_oe[14:0], 32'h0, "oe after reset");
    chk(analog_sel, 32'h00ff, "analog after reset");
  endtask
  task t_disable;
    wr(gpio_share_pkg::OFF_PMB, 32'ha55a);
    wr(gpio_share_pkg::OFF_PMC, 32'hffffffff);
    wr(gpio_share_pkg::OFF_PMA, 32'h2);
    rdr(gpio_share_pkg::OFF_PMC, 32'hf003);
    rdr(gpio_share_pkg::OFF_PMB, 32'ha55a);
    chk(unit_enable, {14'h0, 16'h5aa5, 2'b01}, "unit enables");
    wr(gpio_share_pkg::OFF_PMB, 32'h0);
    wr(gpio_share_pkg::OFF_PMC, 32'h0);
    wr(gpio_share_pkg::OFF_PMA, 32'h0);
  endtask
  task t_port;
    wr(gpio_share_pkg::OFF_DIR, 32'h0);
    wr(gpio_share_pkg::OFF_LAT, 32'hffff);
    rdr(gpio_share_pkg::OFF_LAT, 32'h7fff);
    chk(pin_oe[14:0], 32'h7fff, "port oe");
    chk(pin_out[14:0], 32'h7fff, "port out");
    wr(gpio_share_pkg::OFF_PIN, 32'h1234);
    rdr(gpio_share_pkg::OFF_LAT, 32'h1234);
    rdr(gpio_share_pkg::OFF_PIN, 32'h1200);
    wr(gpio_share_pkg::OFF_PMA, 32'h1);
    idle(3);
    rdr(gpio_share_pkg::OFF_PIN, 32'h1234);
    chk(analog_sel, 32'h0, "analog with adc off");
  endtask
  task t_odc;
    wr(gpio_share_pkg::OFF_ODC, 32'hffff);
    wr(gpio_share_pkg::OFF_LAT, 32'h00f0);
    idle(2);
    chk(pin_oe[14:0], 32'h7f0f, "od oe");
    chk(pin_out & pin_oe, 32'h0, "od low only");
    wr(gpio_share_pkg::OFF_ODC, 32'h0);
  endtask
  task t_share;
    wr(gpio_share_pkg::OFF_LAT, 32'h0);
    drive_val <= 16'h0003;
    drive_req <= 16'h0003;
    idle(3);
    chk(pin_out[1:0], 32'h1, "periph owns pin");
    chk(pin_oe[0], 32'h1, "periph oe");
    rdr(gpio_share_pkg::OFF_PIN, 32'h1);
    drive_req <= 16'h0002;
    idle(3);
    chk(pin_out[1:0], 32'h0, "idle periph");
    drive_req <= 16'h0003;
    wr(gpio_share_pkg::OFF_PMB, 32'h1);
    idle(3);
    chk(pin_out[1:0], 32'h0, "disabled periph");
    drive_req <= 16'h0;
    wr(gpio_share_pkg::OFF_PMB, 32'h0);
  endtask
  task t_loop;
    wr(gpio_share_pkg::OFF_DIR, 32'hffff);
    ext_val <= 16'h5a5a;
    ext_en <= 16'hffff;
    wr(gpio_share_pkg::OFF_LAT, 32'hffff);
    idle(3);
    chk(periph_in[14:0], 32'h5a5a, "loop through");
  endtask
  task t_unmapped;
    rdr(6'h20, 32'h0, gpio_share_pkg::RESP_SLVERR);
    wr(6'h20, 32'hffff, gpio_share_pkg::RESP_SLVERR);
  endtask
  initial begin
    repeat (10) @(posedge sys_clk);
    srst <= 0;
    t_reset;
    t_disable;
    t_port;
    t_odc;
    t_share;
    t_loop;
    t_unmapped;
    close_out;
  end
endmodule
